// *** core/msg_front_end_map.vh ***
// constants for the instrument message front end
`ifndef MSG_FRONT_END_MAP_VH
`define MSG_FRONT_END_MAP_VH
// ****************************************
// characters
// ****************************************
`define CH_NUL 8'h00
`define CH_LF 8'h0a
`define CH_CR 8'h0d
`define CH_XON 8'h11
`define CH_XOFF 8'h13
`define CH_SPACE 8'h20
`define CH_QUOTE 8'h22
`define CH_PERCENT 8'h25
`define CH_COMMA 8'h2c
`define CH_MINUS 8'h2d
`define CH_PLUS 8'h2b
`define CH_DOT 8'h2e
`define CH_COLON 8'h3a
`define CH_SEMI 8'h3b
`define CH_QMARK 8'h3f
// ****************************************
// parsed item classes
// ****************************************
`define CLS_HEADER 4'h0
`define CLS_QUERY 4'h1
`define CLS_CHAR_ARG 4'h2
`define CLS_NUMBER 4'h3
`define CLS_UNIT_FIRST 4'h4
`define CLS_UNIT_REST 4'h5
`define CLS_STRING 4'h6
`define CLS_LINK 4'h7
`define CLS_ARG_SEP 4'h8
`define CLS_BIN_DATA 4'h9
`define CLS_UNIT_END 4'ha
`define CLS_MSG_END 4'hb
// ****************************************
// number forms
// ****************************************
`define FORM_INTEGER 2'h0
`define FORM_DECIMAL 2'h1
`define FORM_EXPONENT 2'h2
// ****************************************
// serial flow modes and terminators
// ****************************************
`define FLOW_WIRE 2'h0
`define FLOW_INBAND 2'h1
`define FLOW_NONE 2'h2
`define STERM_CR 2'h0
`define STERM_LF 2'h1
`define STERM_CRLF 2'h2
// ****************************************
// buffer sizes and flow thresholds
// ****************************************
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define FLOW_HIGH 5'd12
`define FLOW_LOW 5'd4
`endif

// *** core/byte_fifo.v ***
// synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module byte_fifo #(
  parameter W = 9,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire flush_i,
  input wire in_valid_i,
  input wire [W-1:0] in_data_i,
  output wire in_ready_o,
  output wire out_valid_o,
  output wire [W-1:0] out_data_o,
  input wire out_ready_i,
  output wire [AW:0] count_o
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_reg != D[AW:0]);
  assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_reg];
  assign count_o = cnt_reg;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge clock_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
      end
      if (push & !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// *** core/msg_front_end.v ***
// instrument message front end: input parsing, response framing, serial flow
//
// What this block does
// - semicolon separates units; final one optional
// - every response ends with semicolon or LF
// - bus sender marks last byte with EOI
// - bus CR-LF option: CR, LF with EOI
// - serial CR or LF ends input message
// - serial output terminator: CR, LF or CR-LF
// - space separates header from following arguments
// - question mark right after header marks query
// - integer, decimal-point and exponent number forms
// - first unit letter only, decibels in full
// - response numbers carry no unit suffix
// - quoted strings; doubled quote is literal quote
// - colon links, comma separates, never comma last
// - binary block: percent, count, checksum, data, checksum
// - execute while receiving; clear or break stops
// - on error discard rest through terminator
// - responses sent when talker; terminator awaits input end
// - output pauses on untalk/clear; clear empties buffers
// - serial null with framing error is break
// - wire flow: RTS/CTS pace, DTR high
// - in-band flow: XON/XOFF pace, RTS/DTR high
// - no flow: RTS/DTR high, inputs ignored
`timescale 1ns/1ps
`include "msg_front_end_map.vh"
module msg_front_end (
  input wire clock_i,
  input wire rst_n_i,
  input wire serial_sel_i,
  input wire response_separator_select_i,
  input wire gpib_crlf_i,
  input wire [1:0] serial_term_sel_i,
  input wire [1:0] flow_mode_i,
  input wire talk_addressed_i,
  input wire device_clear_i,
  input wire interface_clear_i,
  input wire gpib_rx_valid_i,
  input wire [7:0] gpib_rx_data_i,
  input wire gpib_rx_eoi_i,
  input wire ser_rx_valid_i,
  input wire [7:0] ser_rx_data_i,
  input wire ser_rx_frame_err_i,
  output wire rx_ready_o,
  input wire cts_i,
  output wire rts_o,
  output wire dtr_o,
  output wire item_valid_o,
  output wire [7:0] item_data_o,
  output wire [3:0] item_class_o,
  output wire [1:0] integer_number_form_o,
  input wire item_ready_i,
  output wire parse_error_o,
  output wire break_o,
  output wire busy_o,
  input wire resp_valid_i,
  input wire [7:0] resp_data_i,
  input wire resp_last_i,
  output wire resp_ready_o,
  output wire tx_valid_o,
  output wire [7:0] tx_data_o,
  output wire tx_eoi_o,
  input wire tx_ready_i
);
  // parser states
  localparam P_HEAD = 4'd0;
  localparam P_ARG = 4'd1;
  localparam P_NUM = 4'd2;
  localparam P_USP = 4'd3;
  localparam P_UNIT = 4'd4;
  localparam P_STR = 4'd5;
  localparam P_STRQ = 4'd6;
  localparam P_CHI = 4'd7;
  localparam P_CLO = 4'd8;
  localparam P_CS1 = 4'd9;
  localparam P_BDAT = 4'd10;
  localparam P_CS2 = 4'd11;
  localparam P_DISC = 4'd12;
  localparam P_UDB = 4'd13;
  // transmit states
  localparam T_DATA = 2'd0;
  localparam T_LF = 2'd1;

  function is_digit;
    input [7:0] c;
    begin
      is_digit = (c >= 8'h30) && (c <= 8'h39);
    end
  endfunction

  function is_letter;
    input [7:0] c;
    begin
      is_letter = ((c | 8'h20) >= 8'h61) && ((c | 8'h20) <= 8'h7a);
    end
  endfunction

  // ****************************************
  // pin synchroniser and flow state
  // ****************************************
  reg cts_s1_reg, cts_s2_reg, cts_s3_reg, cts_reg;
  reg xoff_rx_reg, xoff_sent_reg;
  wire [4:0] in_cnt;
  wire inband;
  wire flow_char;
  wire ser_break;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cts_s1_reg <= 1'b0;
      cts_s2_reg <= 1'b0;
      cts_s3_reg <= 1'b0;
      cts_reg <= 1'b0;
    end else begin
      cts_s1_reg <= cts_i;
      cts_s2_reg <= cts_s1_reg;
      cts_s3_reg <= cts_s2_reg;
      if (cts_s2_reg == cts_s3_reg) begin
        cts_reg <= cts_s3_reg;
      end
    end
  end

  assign inband = serial_sel_i & (flow_mode_i == `FLOW_INBAND);
  assign flow_char = inband & ((ser_rx_data_i == `CH_XON) | (ser_rx_data_i == `CH_XOFF));
  assign ser_break = serial_sel_i & ser_rx_valid_i & ser_rx_frame_err_i & (ser_rx_data_i == `CH_NUL);
  assign break_o = ser_break;
  assign dtr_o = 1'b1;
  assign rts_o = !(serial_sel_i & (flow_mode_i == `FLOW_WIRE)) | (in_cnt < `FLOW_HIGH);

  // ****************************************
  // input buffer
  // ****************************************
  wire in_wr_valid;
  wire [8:0] in_wr_data;
  wire in_ready;
  wire in_valid;
  wire [8:0] in_data;
  wire in_pop;
  wire in_flush;

  assign in_flush = device_clear_i | ser_break;
  assign in_wr_valid = serial_sel_i ? (ser_rx_valid_i & !flow_char & !ser_rx_frame_err_i) : gpib_rx_valid_i;
  assign in_wr_data = serial_sel_i ? {1'b0, ser_rx_data_i} : {gpib_rx_eoi_i, gpib_rx_data_i};
  assign rx_ready_o = in_ready;

  byte_fifo #(
    .W(9),
    .D(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) in_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .flush_i(in_flush),
    .in_valid_i(in_wr_valid),
    .in_data_i(in_wr_data),
    .in_ready_o(in_ready),
    .out_valid_o(in_valid),
    .out_data_o(in_data),
    .out_ready_i(in_pop),
    .count_o(in_cnt)
  );

  // ****************************************
  // parser
  // ****************************************
  reg [3:0] st_reg, st_next;
  reg iv_reg;
  reg [7:0] id_reg;
  reg [3:0] ic_reg;
  reg [1:0] form_reg, form_next;
  reg [15:0] bcnt_reg, bcnt_next;
  reg [7:0] sum_reg, sum_next;
  reg comma_reg, comma_next;
  reg err_reg;
  reg msg_done_reg;
  reg emit;
  reg [3:0] ecls;
  reg err;
  reg [3:0] st_eff;
  wire [7:0] b;
  wire in_bin;
  wire term;
  wire take;

  assign b = in_data[7:0];
  assign in_bin = (st_reg >= P_CHI) && (st_reg <= P_CS2);
  assign term = in_data[8] | (!in_bin & (serial_sel_i | gpib_crlf_i) & (b == `CH_LF))
    | (!in_bin & serial_sel_i & (b == `CH_CR));
  assign take = in_valid & (!iv_reg | item_ready_i);
  assign in_pop = take;
  assign item_valid_o = iv_reg;
  assign item_data_o = id_reg;
  assign item_class_o = ic_reg;
  assign integer_number_form_o = form_reg;
  assign parse_error_o = err_reg;
  assign busy_o = in_valid | iv_reg;

  always @* begin
    st_next = st_reg;
    form_next = form_reg;
    bcnt_next = bcnt_reg;
    sum_next = sum_reg;
    comma_next = 1'b0;
    emit = 1'b0;
    ecls = `CLS_HEADER;
    err = 1'b0;
    // closing quote followed by anything but a quote ends the string
    st_eff = (st_reg == P_STRQ && b != `CH_QUOTE) ? P_ARG : st_reg;
    if (st_eff == P_NUM && !is_digit(b) && b != `CH_DOT && (b | 8'h20) != 8'h65
        && b != `CH_PLUS && b != `CH_MINUS) begin
      st_eff = P_USP;
    end
    if ((st_eff == P_USP || st_eff == P_UNIT || st_eff == P_UDB) && !is_letter(b) && b != `CH_SPACE) begin
      st_eff = P_ARG;
    end
    case (st_eff)
      P_HEAD: begin
        if (b == `CH_SEMI) begin
          emit = 1'b1;
          ecls = `CLS_UNIT_END;
        end else if (b == `CH_QMARK) begin
          emit = 1'b1;
          ecls = `CLS_QUERY;
          st_next = P_ARG;
        end else if (b == `CH_SPACE) begin
          st_next = P_ARG;
        end else if (is_letter(b) | is_digit(b)) begin
          emit = 1'b1;
        end else if (b != `CH_CR && !term) begin
          err = 1'b1;
        end
      end
      P_ARG: begin
        emit = 1'b1;
        st_next = P_ARG;
        if (b == `CH_SEMI) begin
          ecls = `CLS_UNIT_END;
          st_next = P_HEAD;
        end else if (b == `CH_COMMA) begin
          ecls = `CLS_ARG_SEP;
          comma_next = 1'b1;
        end else if (b == `CH_COLON) begin
          ecls = `CLS_LINK;
        end else if (b == `CH_QUOTE) begin
          emit = 1'b0;
          st_next = P_STR;
        end else if (b == `CH_PERCENT) begin
          emit = 1'b0;
          sum_next = 8'h00;
          st_next = P_CHI;
        end else if (is_digit(b) | b == `CH_DOT | b == `CH_PLUS | b == `CH_MINUS) begin
          ecls = `CLS_NUMBER;
          form_next = (b == `CH_DOT) ? `FORM_DECIMAL : `FORM_INTEGER;
          st_next = P_NUM;
        end else if (is_letter(b)) begin
          ecls = `CLS_CHAR_ARG;
        end else if (b == `CH_SPACE || b == `CH_CR || term) begin
          emit = 1'b0;
        end else begin
          emit = 1'b0;
          err = 1'b1;
        end
      end
      P_NUM: begin
        emit = 1'b1;
        ecls = `CLS_NUMBER;
        if (b == `CH_DOT && form_reg == `FORM_INTEGER) begin
          form_next = `FORM_DECIMAL;
        end else if ((b | 8'h20) == 8'h65) begin
          form_next = `FORM_EXPONENT;
        end else if (b == `CH_DOT) begin
          emit = 1'b0;
          err = 1'b1;
        end
      end
      P_USP: begin
        if (is_letter(b)) begin
          emit = 1'b1;
          ecls = `CLS_UNIT_FIRST;
          st_next = ((b | 8'h20) == 8'h64) ? P_UDB : P_UNIT;
        end
      end
      P_UDB: begin
        if (is_letter(b)) begin
          emit = 1'b1;
          ecls = `CLS_UNIT_REST;
        end
      end
      P_UNIT: begin
        st_next = P_UNIT;
      end
      P_STR: begin
        if (b == `CH_QUOTE) begin
          st_next = P_STRQ;
        end else begin
          emit = 1'b1;
          ecls = `CLS_STRING;
        end
      end
      P_STRQ: begin
        emit = 1'b1;
        ecls = `CLS_STRING;
        st_next = P_STR;
      end
      P_CHI: begin
        bcnt_next = {b, 8'h00};
        sum_next = sum_reg + b;
        st_next = P_CLO;
      end
      P_CLO: begin
        bcnt_next = {bcnt_reg[15:8], b};
        sum_next = sum_reg + b;
        st_next = P_CS1;
      end
      P_CS1: begin
        sum_next = 8'h00;
        err = ((sum_reg + b) != 8'h00);
        st_next = (bcnt_reg == 16'h0000) ? P_CS2 : P_BDAT;
      end
      P_BDAT: begin
        emit = 1'b1;
        ecls = `CLS_BIN_DATA;
        sum_next = sum_reg + b;
        bcnt_next = bcnt_reg - 16'h0001;
        if (bcnt_reg == 16'h0001) begin
          st_next = P_CS2;
        end
      end
      P_CS2: begin
        err = ((sum_reg + b) != 8'h00);
        st_next = P_ARG;
      end
      P_DISC: begin
        st_next = P_DISC;
      end
      default: begin
        st_next = P_HEAD;
      end
    endcase
    if (err) begin
      emit = 1'b0;
      st_next = P_DISC;
    end
    if (term) begin
      // terminator byte itself is not data; an eoi byte is
      if (!in_data[8] || (!err && st_eff != P_DISC && !emit && b != `CH_LF)) begin
        emit = 1'b0;
      end
      if (comma_reg && !emit) begin
        err = 1'b1;
      end
      if (in_bin && !(st_reg == P_CS2)) begin
        err = 1'b1;
      end
      st_next = P_HEAD;
    end
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= P_HEAD;
      iv_reg <= 1'b0;
      id_reg <= 8'h00;
      ic_reg <= `CLS_HEADER;
      form_reg <= `FORM_INTEGER;
      bcnt_reg <= 16'h0000;
      sum_reg <= 8'h00;
      comma_reg <= 1'b0;
      err_reg <= 1'b0;
    end else if (in_flush) begin
      st_reg <= P_HEAD;
      iv_reg <= 1'b0;
      comma_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      err_reg <= take & err;
      if (item_ready_i) begin
        iv_reg <= 1'b0;
      end
      if (take) begin
        st_reg <= st_next;
        form_reg <= form_next;
        bcnt_reg <= bcnt_next;
        sum_reg <= sum_next;
        comma_reg <= term ? 1'b0 : (comma_next | (comma_reg & !emit));
        if (emit | term) begin
          iv_reg <= 1'b1;
          id_reg <= b;
          ic_reg <= (term && !emit) ? `CLS_MSG_END : ecls;
        end
      end
    end
  end

  // ****************************************
  // response framing and output buffer
  // ****************************************
  reg sep_pend_reg;
  wire o_in_ready, o_valid, o_pop;
  wire [7:0] o_data;
  wire [4:0] o_cnt;

  assign resp_ready_o = !sep_pend_reg & o_in_ready;

  byte_fifo #(
    .W(8),
    .D(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) out_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .flush_i(device_clear_i),
    .in_valid_i(sep_pend_reg | resp_valid_i),
    .in_data_i(sep_pend_reg ? (response_separator_select_i ? `CH_LF : `CH_SEMI) : resp_data_i),
    .in_ready_o(o_in_ready),
    .out_valid_o(o_valid),
    .out_data_o(o_data),
    .out_ready_i(o_pop),
    .count_o(o_cnt)
  );

  // ****************************************
  // transmitter
  // ****************************************
  reg txv_reg, txe_reg, sent_reg;
  reg [7:0] txd_reg;
  reg [1:0] tst_reg;
  wire gpib_eoi_mode, hold_last, send_ok, load, flow_send, end_now;

  assign tx_valid_o = txv_reg;
  assign tx_data_o = txd_reg;
  assign tx_eoi_o = txe_reg;
  assign gpib_eoi_mode = !serial_sel_i & !gpib_crlf_i;
  assign hold_last = gpib_eoi_mode & (o_cnt == 5'd1) & !msg_done_reg;
  assign send_ok = serial_sel_i ? ((flow_mode_i == `FLOW_WIRE) ? cts_reg :
    (flow_mode_i == `FLOW_INBAND) ? !xoff_rx_reg : 1'b1) : (talk_addressed_i & !interface_clear_i);
  assign load = !txv_reg | tx_ready_i;
  assign flow_send = inband & (xoff_sent_reg ? (in_cnt <= `FLOW_LOW) : (in_cnt >= `FLOW_HIGH));
  assign o_pop = load & !flow_send & send_ok & (tst_reg == T_DATA) & o_valid & !hold_last;
  assign end_now = load & !flow_send & send_ok & (tst_reg == T_DATA) & !o_valid & msg_done_reg & sent_reg;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sep_pend_reg <= 1'b0;
      msg_done_reg <= 1'b0;
      xoff_rx_reg <= 1'b0;
      xoff_sent_reg <= 1'b0;
      txv_reg <= 1'b0;
      txe_reg <= 1'b0;
      txd_reg <= 8'h00;
      tst_reg <= T_DATA;
      sent_reg <= 1'b0;
    end else if (device_clear_i) begin
      sep_pend_reg <= 1'b0;
      msg_done_reg <= 1'b0;
      txv_reg <= 1'b0;
      tst_reg <= T_DATA;
      sent_reg <= 1'b0;
    end else begin
      if (resp_valid_i & resp_ready_o & resp_last_i) begin
        sep_pend_reg <= 1'b1;
      end else if (o_in_ready) begin
        sep_pend_reg <= 1'b0;
      end
      if (ser_rx_valid_i & flow_char) begin
        xoff_rx_reg <= (ser_rx_data_i == `CH_XOFF);
      end
      if (take & term) begin
        msg_done_reg <= o_valid | sep_pend_reg | resp_valid_i | sent_reg;
      end else if (end_now | (o_pop & gpib_eoi_mode & (o_cnt == 5'd1))) begin
        msg_done_reg <= 1'b0;
      end
      if (load) begin
        txv_reg <= 1'b0;
        txe_reg <= 1'b0;
        if (flow_send) begin
          txv_reg <= 1'b1;
          txd_reg <= xoff_sent_reg ? `CH_XON : `CH_XOFF;
          xoff_sent_reg <= !xoff_sent_reg;
        end else if (o_pop) begin
          txv_reg <= 1'b1;
          txd_reg <= o_data;
          sent_reg <= 1'b1;
          if (gpib_eoi_mode & (o_cnt == 5'd1)) begin
            txe_reg <= 1'b1;
            sent_reg <= 1'b0;
          end
        end else if (end_now) begin
          txv_reg <= 1'b1;
          sent_reg <= 1'b0;
          if (serial_sel_i & (serial_term_sel_i == `STERM_LF)) begin
            txd_reg <= `CH_LF;
          end else begin
            txd_reg <= `CH_CR;
            tst_reg <= (serial_sel_i & (serial_term_sel_i == `STERM_CR)) ? T_DATA : T_LF;
          end
        end else if ((tst_reg == T_LF) & send_ok & !flow_send) begin
          txv_reg <= 1'b1;
          txd_reg <= `CH_LF;
          txe_reg <= !serial_sel_i;
          tst_reg <= T_DATA;
        end
      end
    end
  end
endmodule

// *** testbench/msg_front_end_props.sv ***
// assertion checker for the message front end
`timescale 1ns/1ps
`include "msg_front_end_map.vh"
module msg_front_end_props (
  input wire clock_i,
  input wire rst_n_i,
  input wire serial_sel_i,
  input wire gpib_crlf_i,
  input wire [1:0] serial_term_sel_i,
  input wire [1:0] flow_mode_i,
  input wire device_clear_i,
  input wire ser_rx_valid_i,
  input wire [7:0] ser_rx_data_i,
  input wire ser_rx_frame_err_i,
  input wire rx_ready_o,
  input wire rts_o,
  input wire dtr_o,
  input wire break_o,
  input wire busy_o,
  input wire resp_valid_i,
  input wire resp_last_i,
  input wire resp_ready_o,
  input wire tx_valid_o,
  input wire [7:0] tx_data_o,
  input wire tx_eoi_o,
  input wire tx_ready_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_resp_end;
    resp_valid_i && resp_ready_o && resp_last_i;
  endsequence
  sequence s_cr_out;
    serial_sel_i && serial_term_sel_i == `STERM_CRLF && tx_valid_o && tx_ready_i && tx_data_o == `CH_CR;
  endsequence
  a_dtr_held: assert property (dtr_o) else $error("dtr low");
  a_rts_free: assert property (flow_mode_i != `FLOW_WIRE |-> rts_o) else $error("rts low");
  a_sep_slot: assert property (s_resp_end |=> !resp_ready_o) else $error("no separator slot");
  a_crlf_pair: assert property (s_cr_out |-> ##[1:40] (tx_valid_o && tx_data_o == `CH_LF))
    else $error("lf missing after cr");
  a_bus_lf_eoi: assert property (!serial_sel_i && gpib_crlf_i && tx_valid_o && tx_eoi_o |-> tx_data_o == `CH_LF)
    else $error("eoi not on lf");
  a_break_seen: assert property (serial_sel_i && ser_rx_valid_i && ser_rx_data_i == `CH_NUL && ser_rx_frame_err_i
    |-> break_o ##1 !busy_o) else $error("break missed");
  a_busy_on_rx: assert property (serial_sel_i && ser_rx_valid_i && rx_ready_o && !ser_rx_frame_err_i
    && flow_mode_i != `FLOW_INBAND && !device_clear_i |=> busy_o) else $error("not busy");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i && !device_clear_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte lost");
endmodule
bind msg_front_end msg_front_end_props chk (.clock_i, .rst_n_i, .serial_sel_i, .gpib_crlf_i, .serial_term_sel_i,
  .flow_mode_i, .device_clear_i, .ser_rx_valid_i, .ser_rx_data_i, .ser_rx_frame_err_i, .rx_ready_o, .rts_o,
  .dtr_o, .break_o, .busy_o, .resp_valid_i, .resp_last_i, .resp_ready_o, .tx_valid_o, .tx_data_o, .tx_eoi_o,
  .tx_ready_i);

// *** testbench/ctrl_model.sv ***
// system controller model: sends message bytes and takes device output
`timescale 1ns/1ps
module ctrl_model (
  input wire clock_i,
  input wire serial_sel_i,
  input wire rx_ready_i,
  input wire stall_i,
  input wire tx_valid_i,
  input wire [7:0] tx_data_i,
  input wire tx_eoi_i,
  output logic gv_o = 0,
  output logic eoi_o = 0,
  output logic sv_o = 0,
  output logic fe_o = 0,
  output logic [7:0] data_o = 0,
  output wire cts_o,
  output wire tx_ready_o
);
  logic [8:0] rx_q[$];
  bit ok;
  assign tx_ready_o = !stall_i;
  assign cts_o = !stall_i;
  always @(posedge clock_i) if (tx_valid_i && tx_ready_o) rx_q.push_back({tx_eoi_i, tx_data_i});
  task put(input logic [7:0] b, input bit last, input bit fe);
    @(negedge clock_i);
    sv_o = serial_sel_i;
    gv_o = !serial_sel_i;
    data_o = b;
    eoi_o = last;
    fe_o = fe;
    forever begin
      ok = rx_ready_i;
      @(posedge clock_i);
      if (ok) break;
      @(negedge clock_i);
    end
    @(negedge clock_i);
    sv_o = 0;
    gv_o = 0;
    eoi_o = 0;
    fe_o = 0;
    data_o = ~b;
  endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking testbench for the message front end
`timescale 1ns/1ps
`include "msg_front_end_map.vh"
module testbench;
  logic clock_i = 0;
  logic rst_n_i = 0;
  logic ser = 1, sep = 0, crlf = 0, talk = 0, dclr = 0, hold = 0, irdy = 0, stall = 0, rv = 0, rl = 0;
  logic [1:0] term = 0, flow = 0;
  logic [7:0] rd = 0, d;
  wire gv, ge, sv, fe, rxr, cts, rts, iv, perr, brk, busy, rr, txv, txe, txr;
  wire [7:0] rxd, id, txd;
  wire [3:0] icls;
  wire [1:0] ifm;
  integer fails = 0, num_checks = 0, seed = 32'h723f5065, n;
  logic [13:0] items[$];
  logic [27:0] want[6] = '{{14'h0fff, 2'h0, `CLS_HEADER, "F"}, {14'h0fff, 2'h0, `CLS_QUERY, "?"},
    {14'h3fff, `FORM_INTEGER, `CLS_NUMBER, "2"}, {14'h3fff, `FORM_DECIMAL, `CLS_NUMBER, "5"},
    {14'h3fff, `FORM_EXPONENT, `CLS_NUMBER, "3"}, {14'h0fff, 2'h0, `CLS_STRING, "\""}};
  bit ok, err, bk;
  msg_front_end uut (.clock_i, .rst_n_i, .serial_sel_i(ser), .response_separator_select_i(sep),
    .gpib_crlf_i(crlf), .serial_term_sel_i(term), .flow_mode_i(flow), .talk_addressed_i(talk),
    .device_clear_i(dclr), .interface_clear_i(1'b0), .gpib_rx_valid_i(gv), .gpib_rx_data_i(rxd),
    .gpib_rx_eoi_i(ge), .ser_rx_valid_i(sv), .ser_rx_data_i(rxd), .ser_rx_frame_err_i(fe), .rx_ready_o(rxr),
    .cts_i(cts), .rts_o(rts), .dtr_o(), .item_valid_o(iv), .item_data_o(id), .item_class_o(icls),
    .integer_number_form_o(ifm), .item_ready_i(irdy), .parse_error_o(perr), .break_o(brk), .busy_o(busy),
    .resp_valid_i(rv), .resp_data_i(rd), .resp_last_i(rl), .resp_ready_o(rr), .tx_valid_o(txv),
    .tx_data_o(txd), .tx_eoi_o(txe), .tx_ready_i(txr));
  ctrl_model ctrl (.clock_i, .serial_sel_i(ser), .rx_ready_i(rxr), .stall_i(stall), .tx_valid_i(txv),
    .tx_data_i(txd), .tx_eoi_i(txe), .gv_o(gv), .eoi_o(ge), .sv_o(sv), .fe_o(fe), .data_o(rxd), .cts_o(cts),
    .tx_ready_o(txr));
  initial forever #2 clock_i = ~clock_i;
  always @(negedge clock_i) begin
    irdy <= !hold && ($random(seed) & 1) != 0;
    stall <= ($random(seed) & 3) == 0;
  end
  always @(posedge clock_i) begin
    if (iv && irdy) items.push_back({ifm, icls, id});
    if (perr) err = 1;
    if (brk) bk = 1;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic bit has(input logic [27:0] w);
    foreach (items[i]) if ((items[i] & w[27:14]) === w[13:0]) return 1;
    return 0;
  endfunction
  function automatic logic [63:0] tx_val();
    logic [63:0] v = 0;
    foreach (ctrl.rx_q[i]) v = {v[55:0], ctrl.rx_q[i][7:0]};
    return v;
  endfunction
  function automatic logic [63:0] exp_out(input logic [1:0] t);
    logic [63:0] e;
    e = {"12", sep ? `CH_LF : `CH_SEMI};
    if (t != `STERM_LF) e = {e[55:0], `CH_CR};
    if (t != `STERM_CR) e = {e[55:0], `CH_LF};
    return e;
  endfunction
  task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (exp !== got) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task done(input string name);
    $display("test %s done", name);
    items.delete();
    ctrl.rx_q.delete();
    err = 0;
  endtask
  task send(input string s, input bit eoi);
    for (int i = 0; i < s.len(); i++) ctrl.put(s[i], eoi && i == s.len() - 1, 0);
  endtask
  task respond(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clock_i);
      rv = 1;
      rd = s[i];
      rl = i == s.len() - 1;
      forever begin
        ok = rr;
        @(posedge clock_i);
        if (ok) break;
        @(negedge clock_i);
      end
    end
    @(negedge clock_i);
    rv = 0;
    rl = 0;
  endtask
  task wait_tx(input integer k);
    for (n = 0; n < 300 && ctrl.rx_q.size() < k; n++) @(negedge clock_i);
  endtask
  task bin_block(input logic [7:0] v, input logic [7:0] bad);
    send("W ", 0);
    ctrl.put("%", 0, 0);
    ctrl.put(8'h00, 0, 0);
    ctrl.put(8'h01, 0, 0);
    ctrl.put(8'hff, 0, 0);
    ctrl.put(v, 0, 0);
    ctrl.put((8'h00 - v) ^ bad, 0, 0);
    send(bad != 0 ? ";Q\n" : ";P\n", 0);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    end_of_test;
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    rst_n_i = 1;
    send("F?\rA 12,1.5,7E3;T \"a\"\"b\"\n", 0);
    repeat (40) @(negedge clock_i);
    foreach (want[i]) chk("item", 1, has(want[i]));
    done("items");
    d = 8'($random(seed));
    bin_block(d, 8'h00);
    bin_block(d, 8'h01);
    send("B\nA 1,\n", 0);
    repeat (40) @(negedge clock_i);
    chk("block data", 1, has({14'h0fff, 2'h0, `CLS_BIN_DATA, d}));
    chk("good block", 1, has({14'h0fff, 2'h0, `CLS_HEADER, "P"}));
    chk("discard", 1, items.size() > 0 && !has({14'h0fff, 2'h0, `CLS_HEADER, "Q"}));
    chk("next msg", 1, has({14'h0fff, 2'h0, `CLS_HEADER, "B"}));
    chk("error", 1, err);
    ctrl.put(8'h00, 0, 1);
    repeat (10) @(negedge clock_i);
    chk("break", 1, bk);
    done("errors");
    hold = 1;
    for (int k = 0; k < 30 && rxr; k++) ctrl.put("A", 0, 0);
    chk("full", 0, {rxr, rts});
    hold = 0;
    send("\n", 0);
    for (n = 0; n < 300 && busy; n++) @(negedge clock_i);
    chk("drained", 2'b01, {busy, rts});
    done("buffer");
    for (int t = 0; t < 3; t++) begin
      term = t[1:0];
      flow = t[1:0];
      sep = t[0];
      send("F?", 0);
      respond("12");
      repeat (60) @(negedge clock_i);
      chk("held", 3, ctrl.rx_q.size());
      send("\r", 0);
      wait_tx(t == 2 ? 5 : 4);
      chk("serial out", exp_out(t[1:0]), tx_val());
      chk("rts", 1, rts);
      done("serial response");
    end
    ser = 0;
    sep = 0;
    for (int c = 0; c < 2; c++) begin
      crlf = c[0];
      talk = 0;
      send("F?", 0);
      respond("7");
      repeat (40) @(negedge clock_i);
      chk("untalked", 0, ctrl.rx_q.size());
      talk = 1;
      repeat (40) @(negedge clock_i);
      chk("bus held", c ? 2 : 1, ctrl.rx_q.size());
      send(";", 1);
      wait_tx(c ? 4 : 2);
      chk("bus out", c ? "7;\r\n" : "7;", tx_val());
      chk("eoi", 1, ctrl.rx_q[$][8]);
      done("bus response");
    end
    talk = 0;
    respond("99");
    dclr = 1;
    @(negedge clock_i);
    dclr = 0;
    talk = 1;
    repeat (40) @(negedge clock_i);
    chk("cleared", 0, ctrl.rx_q.size());
    done("clear");
    end_of_test;
  end
endmodule
